//--- include/tpwm_pkg.sv
// Package with register map, field positions and reset values of the triple PWM unit
package tpwm_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int TPWM_UNITS = 3;
  localparam int TPWM_CNT_W = 16;
  localparam int TPWM_ADDR_W = 8;
  localparam int TPWM_DATA_W = 32;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] TPWM_PERIOD_OFS = 8'h00;
  localparam logic [7:0] TPWM_WIDTH_OFS = 8'h04;
  localparam logic [7:0] TPWM_COUNT_OFS = 8'h08;
  localparam logic [7:0] TPWM_UNIT_STRIDE = 8'h10;
  localparam logic [7:0] TPWM_CTRL_OFS = 8'h30;
  localparam logic [7:0] TPWM_STATUS_OFS = 8'h34;

  // ****************************************
  // Control fields (write 1 to act)
  // ****************************************
  localparam int TPWM_START_ALL_BIT = 0;
  localparam int TPWM_HALT_ONE_BIT = 1;
  localparam int TPWM_HALT_TWO_BIT = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] TPWM_PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] TPWM_WIDTH_RST = 16'h0000;

endpackage : tpwm_pkg

//--- design/tpwm_channel.sv
// One pulse-width modulation channel: counter, wrap and compare
`timescale 1ns/10ps
`default_nettype none
module tpwm_channel
  import tpwm_pkg::*;
#(
  parameter int CNT_W = TPWM_CNT_W
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_halt,
  input wire logic [CNT_W-1:0] i_period,
  input wire logic [CNT_W-1:0] i_width,
  output logic o_run,
  output logic o_tick,
  output logic [CNT_W-1:0] o_count,
  output logic o_pwm
);

  logic run_q;
  logic [CNT_W-1:0] cnt_q;
  logic pwm_q;
  logic tick_q;
  wire logic wrap = (cnt_q >= i_period);
  wire logic [CNT_W-1:0] cnt_nx = wrap ? '0 : cnt_q + 1'b1;
  wire logic [CNT_W-1:0] cnt_d = i_start ? '0 : (run_q ? cnt_nx : cnt_q);
  wire logic run_d = i_start | (run_q & ~i_halt);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      run_q <= 1'b0;
      cnt_q <= '0;
      pwm_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (i_ce) begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      pwm_q <= run_d & (cnt_d < i_width);
      tick_q <= run_q & ~i_start & wrap;
    end
  end

  assign o_run = run_q;
  assign o_count = cnt_q;
  assign o_pwm = pwm_q;
  assign o_tick = tick_q;

endmodule : tpwm_channel
`default_nettype wire

//--- design/tpwm_top.sv
// Top of the triple PWM unit with register port
`timescale 1ns/10ps
`default_nettype none
module tpwm_top
  import tpwm_pkg::*;
#(
  parameter int CNT_W = TPWM_CNT_W
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [TPWM_ADDR_W-1:0] i_addr,
  input wire logic [TPWM_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [TPWM_DATA_W-1:0] o_rdata,
  output logic [TPWM_UNITS-1:0] o_pwm,
  output logic o_sys_tick
);

  // ****************************************
  // Registers and decode
  // ****************************************
  logic [CNT_W-1:0] period_q [TPWM_UNITS];
  logic [CNT_W-1:0] width_q [TPWM_UNITS];
  logic [CNT_W-1:0] count_w [TPWM_UNITS];
  logic [TPWM_UNITS-1:0] run_w;
  logic [TPWM_UNITS-1:0] pwm_w;
  logic [TPWM_UNITS-1:0] tick_w;
  logic [TPWM_DATA_W-1:0] rdata_q;
  logic [TPWM_UNITS-1:0] pwm_q;
  logic tick_q;
  logic [TPWM_DATA_W-1:0] rmux;

  function automatic logic [7:0] reg_addr(input int unit, input logic [7:0] ofs);
    reg_addr = 8'(unit * TPWM_UNIT_STRIDE) + ofs;
  endfunction : reg_addr

  wire logic ctrl_wr = i_wr && (i_addr == TPWM_CTRL_OFS);
  wire logic start_all_units = ctrl_wr & i_wdata[TPWM_START_ALL_BIT];
  wire logic halt_unit_one = ctrl_wr & i_wdata[TPWM_HALT_ONE_BIT];
  wire logic halt_unit_two = ctrl_wr & i_wdata[TPWM_HALT_TWO_BIT];
  // Unit zero cannot be halted
  wire logic [TPWM_UNITS-1:0] halt_vec = {halt_unit_two, halt_unit_one, 1'b0};

  always_comb begin
    rmux = '0;
    for (int u = 0; u < TPWM_UNITS; u++) begin
      if (i_addr == reg_addr(u, TPWM_PERIOD_OFS)) rmux = TPWM_DATA_W'(period_q[u]);
      if (i_addr == reg_addr(u, TPWM_WIDTH_OFS)) rmux = TPWM_DATA_W'(width_q[u]);
      if (i_addr == reg_addr(u, TPWM_COUNT_OFS)) rmux = TPWM_DATA_W'(count_w[u]);
    end
    if (i_addr == TPWM_STATUS_OFS) rmux = TPWM_DATA_W'(run_w);
  end

  // ****************************************
  // Register writes and read data
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      for (int u = 0; u < TPWM_UNITS; u++) begin
        period_q[u] <= CNT_W'(TPWM_PERIOD_RST);
        width_q[u] <= CNT_W'(TPWM_WIDTH_RST);
      end
      rdata_q <= '0;
    end else if (i_ce) begin
      for (int u = 0; u < TPWM_UNITS; u++) begin
        if (i_wr && i_addr == reg_addr(u, TPWM_PERIOD_OFS)) period_q[u] <= i_wdata[CNT_W-1:0];
        if (i_wr && i_addr == reg_addr(u, TPWM_WIDTH_OFS)) width_q[u] <= i_wdata[CNT_W-1:0];
      end
      rdata_q <= i_rd ? rmux : '0;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar g = 0; g < TPWM_UNITS; g++) begin : g_unit
    tpwm_channel #(.CNT_W(CNT_W)) u_chan (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_ce(i_ce),
      .i_start(start_all_units),
      .i_halt(halt_vec[g]),
      .i_period(period_q[g]),
      .i_width(width_q[g]),
      .o_run(run_w[g]),
      .o_tick(tick_w[g]),
      .o_count(count_w[g]),
      .o_pwm(pwm_w[g])
    );
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pwm_q <= '0;
      tick_q <= 1'b0;
    end else if (i_ce) begin
      pwm_q <= pwm_w;
      tick_q <= tick_w[0];
    end
  end

  assign o_rdata = rdata_q;
  assign o_pwm = pwm_q;
  assign o_sys_tick = tick_q;

  // ****************************************
  // Checks
  // ****************************************
  start_sync_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && start_all_units) |=> (run_w == '1 && count_w[0] == '0 && count_w[2] == '0))
    else $error("start did not launch all units together");
  unit0_nohalt_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[0]) |=> run_w[0])
    else $error("unit zero stopped");
  halt_one_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && halt_unit_one && !start_all_units) |=> !run_w[1])
    else $error("unit one kept running after halt");
  count_adv_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[0] && !start_all_units && count_w[0] < period_q[0])
    |=> count_w[0] == $past(count_w[0]) + 1'b1)
    else $error("count did not advance");
  wrap_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[1] && !halt_unit_one && count_w[1] >= period_q[1]) |=> count_w[1] == '0)
    else $error("count did not wrap");
  pwm_cmp_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[2]) |=> ##1 ($past(i_ce) -> o_pwm[2] == $past(run_w[2] && count_w[2] < width_q[2])))
    else $error("pwm output does not match compare");
  stop_idle_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !run_w[1] && !start_all_units) |=> (count_w[1] == $past(count_w[1]) && !pwm_w[1]))
    else $error("stopped unit not idle");
  sys_tick_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[0] && !start_all_units && count_w[0] >= period_q[0]) |=> ##1 ($past(i_ce) -> o_sys_tick))
    else $error("system tick missing");
  read_data_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_rd && i_addr == TPWM_PERIOD_OFS) |=> o_rdata == TPWM_DATA_W'($past(period_q[0])))
    else $error("period read back wrong");

  // ****************************************
  // Checks on reads, writes, halts, freeze, reset, start, counting, wrap, tick and outputs
  // ****************************************
  halt_two_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && halt_unit_two && !start_all_units) |=> !run_w[2])
    else $error("unit two kept running after halt");
  rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !i_rd) |=> o_rdata == '0)
    else $error("read data not cleared");
  reset_idle_a: assert property (@(posedge i_clk)
    !i_reset_n |=> (run_w == '0 && o_pwm == '0 && !o_sys_tick && count_w[0] == '0))
    else $error("reset did not idle the units");
  width_read_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_rd && i_addr == TPWM_WIDTH_OFS) |=> o_rdata == TPWM_DATA_W'($past(width_q[0])))
    else $error("width read back wrong");
  status_read_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_rd && i_addr == TPWM_STATUS_OFS) |=> o_rdata == TPWM_DATA_W'($past(run_w)))
    else $error("status read back wrong");
  count_read_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_rd && i_addr == TPWM_COUNT_OFS) |=> o_rdata == TPWM_DATA_W'($past(count_w[0])))
    else $error("count read back wrong");
  ce_freeze_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_ce |=> (count_w[0] == $past(count_w[0]) && run_w == $past(run_w) && o_rdata == $past(o_rdata)))
    else $error("state moved while clock enable low");
  stay_stopped_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !run_w[2] && !start_all_units) |=> !run_w[2])
    else $error("stopped unit started without start");
  halt_keep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !run_w[2] && !start_all_units) |=> count_w[2] == $past(count_w[2]))
    else $error("halted unit count moved");
  start_count_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && start_all_units) |=> count_w[1] == '0)
    else $error("unit one not restarted at zero");
  unit1_pwm_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[1]) |=> ##1 ($past(i_ce) -> o_pwm[1] == $past(run_w[1] && count_w[1] < width_q[1])))
    else $error("unit one output does not match compare");
  unit0_pwm_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[0]) |=> ##1 ($past(i_ce) -> o_pwm[0] == $past(run_w[0] && count_w[0] < width_q[0])))
    else $error("unit zero output does not match compare");
  count_adv1_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[1] && !start_all_units && !halt_unit_one && count_w[1] < period_q[1])
    |=> count_w[1] == $past(count_w[1]) + 1'b1)
    else $error("unit one count did not advance");
  count_adv2_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[2] && !start_all_units && !halt_unit_two && count_w[2] < period_q[2])
    |=> count_w[2] == $past(count_w[2]) + 1'b1)
    else $error("unit two count did not advance");
  wrap_zero0_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[0] && count_w[0] >= period_q[0]) |=> count_w[0] == '0)
    else $error("unit zero count did not wrap");
  wrap_zero2_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && run_w[2] && !halt_unit_two && count_w[2] >= period_q[2]) |=> count_w[2] == '0)
    else $error("unit two count did not wrap");
  tick_only_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !(run_w[0] && !start_all_units && count_w[0] >= period_q[0]))
    |=> ##1 ($past(i_ce) -> !o_sys_tick))
    else $error("system tick without wrap");
  pwm_idle0_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !run_w[0] && !start_all_units) |=> ##1 ($past(i_ce) -> !o_pwm[0]))
    else $error("stopped unit zero output active");
  pwm_idle2_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !run_w[2] && !start_all_units) |=> ##1 ($past(i_ce) -> !o_pwm[2]))
    else $error("halted unit two output active");
  width_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_wr && i_addr == TPWM_UNIT_STRIDE + TPWM_WIDTH_OFS)
    |=> width_q[1] == $past(i_wdata[CNT_W-1:0]))
    else $error("width write lost");
  period_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_wr && i_addr == TPWM_PERIOD_OFS) |=> period_q[0] == $past(i_wdata[CNT_W-1:0]))
    else $error("period write lost");

endmodule : tpwm_top
`default_nettype wire

//--- verif/tb.sv
// Self-checking testbench for the triple PWM unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tpwm_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ce = 1'b1;
  logic [31:0] o_rdata;
  logic [2:0] o_pwm;
  logic o_sys_tick;
  int fail_count = 0;
  int checks_done = 0;
  always #5 i_clk = ~i_clk;
  tpwm_top uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pwm(o_pwm),
    .o_sys_tick(o_sys_tick));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Leaves the write strobe up so a read may follow with no gap
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_rd <= 1'b0;
    i_wr <= 1'b1;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
    @(posedge i_clk);
  endtask : rd
  // Counts high cycles of a PWM output (0..2) or of the tick (3)
  task automatic pulses(input int sel, input int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge i_clk);
      if ((sel == 3 ? o_sys_tick : o_pwm[sel]) === 1'b1) k++;
    end
    @(posedge i_clk);
  endtask : pulses
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] d;
    rd(8'h00, d); chk("period0", d, {16'h0000, TPWM_PERIOD_RST});
    @(negedge i_clk);
    chk("rdata idle", o_rdata, 32'h0000_0000);
    @(posedge i_clk);
    rd(8'h14, d); chk("width1", d, 32'h0000_0000);
    rd(8'h18, d); chk("count1", d, 32'h0000_0000);
    rd(TPWM_STATUS_OFS, d); chk("status", d, 32'h0000_0000);
    rd(8'h3C, d); chk("unmapped", d, 32'h0000_0000);
    chk("pwm idle", {29'h0, o_pwm}, 32'h0000_0000);
  endtask : t_reset
  task automatic t_regs;
    logic [31:0] d;
    wr(8'h10, 32'hFFFF_0003);
    wr(8'h14, 32'h0000_0002);
    wr(8'h20, 32'h0000_0004);
    wr(8'h24, 32'h0000_0001);
    wr(8'h00, 32'h0000_0004);
    wr(8'h04, 32'h0000_0004);
    rd(8'h10, d); chk("period1", d, 32'h0000_0003);
    rd(8'h24, d); chk("width2", d, 32'h0000_0001);
    chk("pwm stopped", {29'h0, o_pwm}, 32'h0000_0000);
  endtask : t_regs
  task automatic t_start;
    logic [31:0] d;
    wr(TPWM_CTRL_OFS, 32'h0000_0001);
    rd(8'h08, d); chk("count0", d, 32'h0000_0000);
    rd(8'h18, d); chk("count1", d, 32'h0000_0002);
    rd(8'h28, d); chk("count2", d, 32'h0000_0004);
  endtask : t_start
  task automatic t_wave;
    int k;
    pulses(1, 12, k); chk("pwm1 highs", k, 6);
    pulses(2, 10, k); chk("pwm2 highs", k, 2);
    pulses(0, 10, k); chk("pwm0 highs", k, 8);
    pulses(3, 10, k); chk("ticks", k, 2);
  endtask : t_wave
  task automatic t_halt;
    logic [31:0] d, e;
    int k;
    wr(TPWM_CTRL_OFS, 32'h0000_0004);
    rd(TPWM_STATUS_OFS, d); chk("status", d, 32'h0000_0003);
    rd(8'h28, d);
    rd(8'h28, e); chk("frozen", e, d);
    pulses(2, 10, k); chk("pwm2 halted", k, 0);
    wr(TPWM_CTRL_OFS, 32'h0000_0002);
    rd(TPWM_STATUS_OFS, d); chk("status", d, 32'h0000_0001);
    pulses(0, 10, k); chk("pwm0 runs", k, 8);
  endtask : t_halt
  // Six frozen cycles, then unit zero resumes; its period goes back to the reset value
  task automatic t_freeze;
    logic [31:0] d, e;
    rd(8'h08, d);
    i_ce <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_ce <= 1'b1;
    rd(8'h08, e); chk("count frozen", e, (d + 32'h0000_0002) % 32'h0000_0005);
    wr(8'h00, {16'h0000, TPWM_PERIOD_RST});
    rd(8'h00, d); chk("period0 kept", d, {16'h0000, TPWM_PERIOD_RST});
  endtask : t_freeze
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_regs();
    t_start();
    t_wave();
    t_halt();
    t_freeze();
    test_done();
  end
endmodule : tb
`default_nettype wire
